// [verilog/cfid_pkg.sv]
// Shared constants, types and register map of the core feature identification block
package cfid_pkg;

    localparam int unsigned CFID_ADDR_W = 12;
    localparam int unsigned CFID_DATA_W = 32;
    localparam int unsigned CFID_CNT_W = 8;

    // Register byte offsets
    localparam logic [11:0] CFID_OFF_ID3 = 12'h000;
    localparam logic [11:0] CFID_OFF_CTRL = 12'h004;
    localparam logic [11:0] CFID_OFF_STAT = 12'h008;

    // Control register fields
    localparam int unsigned CFID_CTRL_ERR_BIT = 0;
    localparam int unsigned CFID_CTRL_WAIT_BIT = 1;
    localparam int unsigned CFID_CTRL_W = 2;
    localparam logic [1:0] CFID_CTRL_RST = 2'h0;

    // Status register fields
    localparam int unsigned CFID_STAT_STICKY_BIT = 0;
    localparam int unsigned CFID_STAT_CNT_LSB = 8;
    localparam logic CFID_STICKY_RST = 1'b0;
    localparam logic [7:0] CFID_CNT_RST = 8'h00;
    localparam logic [7:0] CFID_CNT_MAX = 8'hff;

    // Field values of the identification word
    localparam logic CFID_VAL_RESV31 = 1'b0;
    localparam logic [7:0] CFID_VAL_UNIMP_30_23 = 8'h00;
    localparam logic [1:0] CFID_VAL_PRIO_W = 2'h1;
    localparam logic [2:0] CFID_VAL_CISA_REV = 3'h0;
    localparam logic CFID_VAL_MCU_ASE = 1'b1;
    localparam logic CFID_VAL_EXC_ISA = 1'b1;
    localparam logic [1:0] CFID_VAL_ISA_AVAIL = 2'h1;
    localparam logic CFID_VAL_USER_LOCAL = 1'b1;
    localparam logic CFID_VAL_RX_INHIBIT = 1'b1;
    localparam logic [2:0] CFID_VAL_UNIMP_11_9 = 3'h0;
    localparam logic CFID_VAL_FLOW_TRACE = 1'b0;
    localparam logic CFID_VAL_UNIMP_7 = 1'b0;
    localparam logic CFID_VAL_EXT_INT = 1'b1;
    localparam logic CFID_VAL_VEC_INT = 1'b1;
    localparam logic CFID_VAL_SMALL_PAGE = 1'b0;
    localparam logic CFID_VAL_DEV_MAP = 1'b1;
    localparam logic [1:0] CFID_VAL_UNIMP_2_1 = 2'h0;
    localparam logic CFID_VAL_TRACE_LOGIC = 1'b0;

    // Bit layout, msb first: 31, 30:23, 22:21, 20:18, 17, 16, 15:14, 13, 12, 11:9, 8, 7, 6, 5, 4, 3, 2:1, 0
    typedef struct packed {
        logic resv31;
        logic [7:0] unimp_30_23;
        logic [1:0] priority_field_width;
        logic [2:0] compressed_isa_revision;
        logic mcu_ase_present;
        logic exception_entry_isa;
        logic [1:0] instruction_set_availability;
        logic user_local_reg_present;
        logic read_exec_inhibit_present;
        logic [2:0] unimp_11_9;
        logic flow_trace_present;
        logic unimp_7;
        logic external_int_ctrl_support;
        logic vectored_int_support;
        logic small_page_option;
        logic device_memory_map_present;
        logic [1:0] unimp_2_1;
        logic trace_logic_present;
    } cfid_feat_s;

    localparam cfid_feat_s CFID_FEAT_RST = '{
        resv31: CFID_VAL_RESV31,
        unimp_30_23: CFID_VAL_UNIMP_30_23,
        priority_field_width: CFID_VAL_PRIO_W,
        compressed_isa_revision: CFID_VAL_CISA_REV,
        mcu_ase_present: CFID_VAL_MCU_ASE,
        exception_entry_isa: CFID_VAL_EXC_ISA,
        instruction_set_availability: CFID_VAL_ISA_AVAIL,
        user_local_reg_present: CFID_VAL_USER_LOCAL,
        read_exec_inhibit_present: CFID_VAL_RX_INHIBIT,
        unimp_11_9: CFID_VAL_UNIMP_11_9,
        flow_trace_present: CFID_VAL_FLOW_TRACE,
        unimp_7: CFID_VAL_UNIMP_7,
        external_int_ctrl_support: CFID_VAL_EXT_INT,
        vectored_int_support: CFID_VAL_VEC_INT,
        small_page_option: CFID_VAL_SMALL_PAGE,
        device_memory_map_present: CFID_VAL_DEV_MAP,
        unimp_2_1: CFID_VAL_UNIMP_2_1,
        trace_logic_present: CFID_VAL_TRACE_LOGIC
    };

    typedef enum logic [1:0] {
        CFID_IDLE,
        CFID_WAIT,
        CFID_RESP
    } cfid_apb_e;

endpackage

// [verilog/cfid_feat_reg.sv]
// Holding register for the identification word, reloaded every clock
`timescale 1ns/1ps
module cfid_feat_reg
    import cfid_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire cfid_feat_s feat_in,
    output cfid_feat_s feat_ff
);

    // Reloading each cycle means a disturbed flop heals on the next edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            feat_ff <= CFID_FEAT_RST;
        end
        else
        begin
            feat_ff <= feat_in;
        end
    end

endmodule

// [verilog/cfid_sat_cnt.sv]
// Saturating event counter with synchronous clear
`timescale 1ns/1ps
module cfid_sat_cnt
    import cfid_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic inc,
    input wire logic clr,
    output logic [CFID_CNT_W-1:0] cnt_ff
);

    logic [CFID_CNT_W-1:0] nxt_cnt;

    // An increment in the clearing cycle survives as a count of one
    always_comb
    begin
        nxt_cnt = cnt_ff;
        if (clr)
        begin
            nxt_cnt = inc ? CFID_CNT_RST + 8'h01 : CFID_CNT_RST;
        end
        else if (inc && cnt_ff != CFID_CNT_MAX)
        begin
            nxt_cnt = cnt_ff + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_ff <= CFID_CNT_RST;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
        end
    end

endmodule

// [verilog/cfid_top.sv]
// Core feature identification register 3 with APB and coprocessor read ports
`timescale 1ns/1ps
module cfid_top
    import cfid_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [CFID_ADDR_W-1:0] paddr,
    input wire logic [CFID_DATA_W-1:0] pwdata,
    output logic [CFID_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cop_rd_req,
    input wire logic cop_wr_req,
    output logic [CFID_DATA_W-1:0] cop_rd_data,
    output logic cop_rd_valid,
    output cfid_feat_s core_feature_id3
);

    cfid_apb_e state_ff;
    cfid_apb_e nxt_state;
    cfid_feat_s feat_hw;
    cfid_feat_s feat_q;
    logic [CFID_CTRL_W-1:0] ctrl_ff;
    logic sticky_ff;
    logic nxt_sticky;
    logic [CFID_CNT_W-1:0] wr_cnt;
    logic [CFID_DATA_W-1:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [CFID_DATA_W-1:0] cop_rd_data_ff;
    logic cop_rd_valid_ff;
    logic [CFID_DATA_W-1:0] rd_mux;
    logic rd_err;
    logic hit_id3;
    logic hit_ctrl;
    logic hit_stat;
    logic commit;
    logic ro_wr_apb;
    logic ro_wr_any;
    logic stat_clr;

    // Fixed capability fields
    always_comb
    begin
        feat_hw = CFID_FEAT_RST;
        feat_hw.resv31 = CFID_VAL_RESV31;
        feat_hw.unimp_30_23 = CFID_VAL_UNIMP_30_23;
        feat_hw.unimp_11_9 = CFID_VAL_UNIMP_11_9;
        feat_hw.unimp_7 = CFID_VAL_UNIMP_7;
        feat_hw.unimp_2_1 = CFID_VAL_UNIMP_2_1;
        feat_hw.priority_field_width = CFID_VAL_PRIO_W;
        feat_hw.compressed_isa_revision = CFID_VAL_CISA_REV;
        feat_hw.mcu_ase_present = CFID_VAL_MCU_ASE;
        feat_hw.exception_entry_isa = CFID_VAL_EXC_ISA;
        feat_hw.instruction_set_availability = CFID_VAL_ISA_AVAIL;
        feat_hw.user_local_reg_present = CFID_VAL_USER_LOCAL;
        feat_hw.read_exec_inhibit_present = CFID_VAL_RX_INHIBIT;
        feat_hw.flow_trace_present = CFID_VAL_FLOW_TRACE;
        feat_hw.external_int_ctrl_support = CFID_VAL_EXT_INT;
        feat_hw.vectored_int_support = CFID_VAL_VEC_INT;
        feat_hw.small_page_option = CFID_VAL_SMALL_PAGE;
        feat_hw.device_memory_map_present = CFID_VAL_DEV_MAP;
        feat_hw.trace_logic_present = CFID_VAL_TRACE_LOGIC;
    end

    // No write path reaches this register at all
    cfid_feat_reg i_cfid_feat_reg (
        .pclk(pclk),
        .presetn(presetn),
        .feat_in(feat_hw),
        .feat_ff(feat_q)
    );

    // Address decode; only full word offsets match
    assign hit_id3 = (paddr == CFID_OFF_ID3);
    assign hit_ctrl = (paddr == CFID_OFF_CTRL);
    assign hit_stat = (paddr == CFID_OFF_STAT);

    // Write takes effect at the edge that samples pready high
    assign commit = psel && penable && pready_ff;
    assign ro_wr_apb = commit && pwrite && hit_id3;
    assign ro_wr_any = ro_wr_apb || cop_wr_req;
    assign stat_clr = commit && pwrite && hit_stat && pwdata[CFID_STAT_STICKY_BIT];

    // Read data and error answer
    always_comb
    begin
        rd_mux = '0;
        rd_err = 1'b0;
        if (hit_id3)
        begin
            rd_mux = feat_q;
            rd_err = pwrite && ctrl_ff[CFID_CTRL_ERR_BIT];
        end
        else if (hit_ctrl)
        begin
            rd_mux[CFID_CTRL_W-1:0] = ctrl_ff;
        end
        else if (hit_stat)
        begin
            rd_mux[CFID_STAT_STICKY_BIT] = sticky_ff;
            rd_mux[CFID_STAT_CNT_LSB +: CFID_CNT_W] = wr_cnt;
        end
        else
        begin
            rd_err = 1'b1;
        end
    end

    // Access sequencing: one wait cycle, two with the wait option
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            CFID_IDLE:
            begin
                if (psel && penable)
                begin
                    nxt_state = ctrl_ff[CFID_CTRL_WAIT_BIT] ? CFID_WAIT : CFID_RESP;
                end
            end
            CFID_WAIT:
            begin
                nxt_state = CFID_RESP;
            end
            CFID_RESP:
            begin
                nxt_state = CFID_IDLE;
            end
            default:
            begin
                nxt_state = CFID_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= CFID_IDLE;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // Ready pulse; rises in the cycle after the access phase is seen, or one cycle later with the wait option
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
        end
        else
        begin
            pready_ff <= (nxt_state == CFID_RESP);
        end
    end

    // Error answer only stands together with pready
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pslverr_ff <= 1'b0;
        end
        else if (nxt_state == CFID_RESP)
        begin
            pslverr_ff <= rd_err;
        end
        else
        begin
            pslverr_ff <= 1'b0;
        end
    end

    // Read data captured in the cycle before pready rises; zero otherwise
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff <= '0;
        end
        else if (nxt_state == CFID_RESP && !pwrite)
        begin
            prdata_ff <= rd_mux;
        end
        else
        begin
            prdata_ff <= '0;
        end
    end

    // Control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_ff <= CFID_CTRL_RST;
        end
        else if (commit && pwrite && hit_ctrl)
        begin
            ctrl_ff <= pwdata[CFID_CTRL_W-1:0];
        end
    end

    // Sticky flag for ignored writes; a new attempt beats the clear
    always_comb
    begin
        nxt_sticky = sticky_ff;
        if (stat_clr)
        begin
            nxt_sticky = 1'b0;
        end
        if (ro_wr_any)
        begin
            nxt_sticky = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sticky_ff <= CFID_STICKY_RST;
        end
        else
        begin
            sticky_ff <= nxt_sticky;
        end
    end

    // Counts ignored writes from either port, saturating
    cfid_sat_cnt i_cfid_sat_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .inc(ro_wr_any),
        .clr(stat_clr),
        .cnt_ff(wr_cnt)
    );

    // Coprocessor read path answers one cycle after the request
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cop_rd_valid_ff <= 1'b0;
        end
        else
        begin
            cop_rd_valid_ff <= cop_rd_req;
        end
    end

    // Data idles at zero so the core may merge several sources by OR
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cop_rd_data_ff <= '0;
        end
        else if (cop_rd_req)
        begin
            cop_rd_data_ff <= feat_q;
        end
        else
        begin
            cop_rd_data_ff <= '0;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign cop_rd_data = cop_rd_data_ff;
    assign cop_rd_valid = cop_rd_valid_ff;
    assign core_feature_id3 = feat_q;

endmodule

// [dv/cfid_top_asserts.sv]
// Port checks for the identification register block
`timescale 1ns/1ps
module cfid_top_asserts
    import cfid_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [CFID_ADDR_W-1:0] paddr,
    input wire logic [CFID_DATA_W-1:0] pwdata,
    input wire logic [CFID_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cop_rd_req,
    input wire logic cop_wr_req,
    input wire logic [CFID_DATA_W-1:0] cop_rd_data,
    input wire logic cop_rd_valid,
    input wire cfid_feat_s core_feature_id3
);
    localparam logic [31:0] ID_WORD = 32'h0023_7068;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_resv;
        core_feature_id3[31] == 1'b0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bit set");
    property p_unimp;
        core_feature_id3[30:23] == 8'h00 && core_feature_id3[11:9] == 3'h0 && !core_feature_id3[7]
            && core_feature_id3[2:1] == 2'h0;
    endproperty
    a_unimp: assert property (p_unimp) else $error("unimplemented bit set");
    property p_fields;
        core_feature_id3[22:21] == 2'h1 && core_feature_id3[20:18] == 3'h0 && core_feature_id3[15:14] == 2'h1;
    endproperty
    a_fields: assert property (p_fields) else $error("multi-bit field wrong");
    property p_ones;
        &{core_feature_id3[17], core_feature_id3[16], core_feature_id3[13], core_feature_id3[12],
          core_feature_id3[6], core_feature_id3[5], core_feature_id3[3]};
    endproperty
    a_ones: assert property (p_ones) else $error("feature bit clear");
    property p_zeros;
        !(core_feature_id3[8] || core_feature_id3[4] || core_feature_id3[0]);
    endproperty
    a_zeros: assert property (p_zeros) else $error("absent feature reported");
    // Coprocessor path must deliver the same word one cycle on
    property p_cop;
        cop_rd_req |=> cop_rd_valid && cop_rd_data == ID_WORD;
    endproperty
    a_cop: assert property (p_cop) else $error("coprocessor read wrong");
    property p_wr_ignored;
        (cop_wr_req || (psel && penable && pwrite)) |=> $stable(core_feature_id3);
    endproperty
    a_wr_ignored: assert property (p_wr_ignored) else $error("word changed by write");
    property p_apb_rd;
        pready && psel && !pwrite && paddr == CFID_OFF_ID3 |-> prdata == ID_WORD;
    endproperty
    a_apb_rd: assert property (p_apb_rd) else $error("bus read of word wrong");
    c_cop: cover property (cop_rd_req ##1 cop_rd_valid);
    c_rd: cover property (pready && !pwrite && paddr == CFID_OFF_ID3);
    c_err: cover property (pready && pslverr);
endmodule
bind cfid_top cfid_top_asserts i_cfid_top_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cop_rd_req(cop_rd_req), .cop_wr_req(cop_wr_req), .cop_rd_data(cop_rd_data),
    .cop_rd_valid(cop_rd_valid), .core_feature_id3(core_feature_id3));

// [dv/test_cfid_top.sv]
// Testbench for the identification register block
`timescale 1ns/1ps
module test_cfid_top
    import cfid_pkg::*;
;
    // Expected word built field by field, msb first
    localparam logic [31:0] EXP = {1'b0, 8'h00, 2'h1, 3'h0, 1'b1, 1'b1, 2'h1, 1'b1, 1'b1, 3'h0, 1'b0, 1'b0,
        1'b1, 1'b1, 1'b0, 1'b1, 2'h0, 1'b0};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cop_rd_req, cop_wr_req, cop_rd_valid, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, cop_rd_data, r;
    cfid_feat_s core_feature_id3;
    int err_total, n_tests;
    cfid_top i_cfid_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cop_rd_req(cop_rd_req), .cop_wr_req(cop_wr_req), .cop_rd_data(cop_rd_data),
        .cop_rd_valid(cop_rd_valid), .core_feature_id3(core_feature_id3));
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task finish_test;
    begin
        $display("Compares %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
    begin
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    end
    endtask
    // Idle cycle first so a release and a new setup never share a step
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd, output logic er);
        int n;
    begin
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 8);
        if (pready !== 1'b1)
        begin
            err_total++;
            $display("ERROR t=%0t bus answer timed out", $time);
            finish_test;
        end
        else
        begin
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    end
    endtask
    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, cop_rd_req, cop_wr_req} = 5'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        err_total = 0;
        n_tests = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CFID_OFF_ID3, 32'h0, r, e);
        check(r, EXP);
        apb(1'b1, CFID_OFF_ID3, 32'hffff_ffff, r, e);
        check(32'(e), 32'h0);
        apb(1'b1, CFID_OFF_ID3, 32'h0, r, e);
        @(posedge pclk);
        cop_wr_req <= 1'b1;
        @(posedge pclk);
        cop_wr_req <= 1'b0;
        apb(1'b1, CFID_OFF_CTRL, 32'h1, r, e);
        apb(1'b1, CFID_OFF_ID3, 32'h5a5a_a5a5, r, e);
        check(32'(e), 32'h1);
        check(core_feature_id3, EXP);
        apb(1'b0, CFID_OFF_STAT, 32'h0, r, e);
        check(r, 32'h0000_0401);
        apb(1'b1, CFID_OFF_STAT, 32'h1, r, e);
        apb(1'b0, CFID_OFF_STAT, 32'h0, r, e);
        check(r, 32'h0);
        apb(1'b1, CFID_OFF_CTRL, 32'h2, r, e);
        apb(1'b0, CFID_OFF_ID3, 32'h0, r, e);
        check(r, EXP);
        apb(1'b0, 12'h00c, 32'h0, r, e);
        check({r[31:1], e}, 32'h1);
        // Two requests back to back, answered on consecutive cycles
        cop_rd_req <= 1'b1;
        @(posedge pclk);
        repeat (2)
        begin
            @(posedge pclk);
            cop_rd_req <= 1'b0;
            check({cop_rd_data[31:1], cop_rd_valid}, {EXP[31:1], 1'b1});
        end
        @(posedge pclk);
        check({cop_rd_data[31:1], cop_rd_valid}, 32'h0);
        presetn <= 1'b0;
        @(posedge pclk);
        check(core_feature_id3, EXP);
        check(prdata, 32'h0);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CFID_OFF_CTRL, 32'h0, r, e);
        check(r, 32'h0);
        finish_test;
    end
endmodule
